// >>> hdl/timer_modes.sv
`timescale 1ns/10ps
//Function
// - Frequency output toggles giving timer clock over twice the channel value.
// - Frequency value is 0 to 255; zero acts as 256.
// - Source codes 0-2 give 4/12/48 MHz plain; 3-6 give 1/4/12/48 divided.
// - Frequency output starts only when the shared 256-tick timer roll occurs.
// - Quadrature uses pair 0/1 or 2/3; even is phase A, odd phase B.
// - An edge on one phase alone counts once; direction from phase order.
// - Count is signed 32-bit, read identically through either pair channel in quadrature mode.
// - Writing zero to either pair channel clears the shared count.
// - A read returns the count held before a reset in the same request.
// - Value bit 15 enables index zeroing, bits 4:0 select the index line.
// - Index line is looked at only when a phase edge is seen.
// - Stop input on odd channel counts rising pin edges in 16 bits.
// - Edge count equal to stop count halts the adjacent even output.
// - Rewriting a halted output's mode re-arms it for one cycle only unless the odd channel was reconfigured first.
// - Halted output stays enabled but releases its pin to pulled-up input.
// - Stop read gives counted edges high, saturating, and edges awaited low.
// - Clock source and divider are shared by every channel.
module timer_modes
	import timer_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_b_i,
	input  wire logic [7:0]              reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [31:0]             reg_rdata_o,
	input  wire logic [NUM_CH-1:0]       pin_i,
	output logic      [NUM_CH-1:0]       pin_o,
	output logic      [NUM_CH-1:0]       pin_oe_o,
	input  wire logic [timer_pkg::DIO_W-1:0] dio_i
);
	import timer_pkg::*;

	localparam int NUM_PAIR = NUM_CH / 2;

	if (NUM_CH != 2 && NUM_CH != 4) begin : g_bad_num_ch
		$error("timer_modes: NUM_CH must be 2 or 4");
	end

	typedef struct packed {
		logic [2:0]                       src;
		logic [7:0]                       div;
		mode_t     [NUM_CH-1:0]           mode;
		logic      [NUM_CH-1:0][VAL_W-1:0] val;
		logic [ACC_W-1:0]                 acc;
		logic [7:0]                       div_cnt;
		logic [7:0]                       roll;
		fo_state_t [NUM_CH-1:0]           st;
		logic      [NUM_CH-1:0][7:0]      hc;
		logic [NUM_CH-1:0]                out;
		logic [NUM_CH-1:0]                prev;
		logic      [NUM_PAIR-1:0][QCNT_W-1:0] qcnt;
		logic      [NUM_PAIR-1:0][VAL_W-1:0]  edges;
		logic [31:0]                      rdata;
	} state_t;

	state_t                  q;
	state_t                  d;
	logic [NUM_CH-1:0]       pin_s;
	logic [DIO_W-1:0]        dio_s;

	// Channel registers sit at base plus four times the channel number
	function automatic logic bank_hit(input logic [7:0] a,
	                                  input logic [7:0] base);
		bank_hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00) &&
		           (int'(a[3:2]) < NUM_CH);
	endfunction : bank_hit

	function automatic logic [1:0] bank_ch(input logic [7:0] a);
		bank_ch = a[3:2];
	endfunction : bank_ch

	pin_sync #(
		.W (NUM_CH + DIO_W)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   ({dio_i, pin_i}),
		.sync_o    ({dio_s, pin_s})
	);

	always_comb begin
		logic [ACC_W:0]        acc_sum;
		logic                  base_tick;
		logic                  t_tick;
		logic                  roll_ev;
		logic                  zero_wr;
		logic                  a_now;
		logic                  b_now;
		logic                  a_chg;
		logic                  b_chg;
		logic [VAL_W-1:0]      cfg;
		logic [QCNT_W-1:0]     cnt;
		logic [1:0]            c;
		int                    e;
		int                    o;
		acc_sum   = '0;
		base_tick = 1'b0;
		t_tick    = 1'b0;
		roll_ev   = 1'b0;
		zero_wr   = 1'b0;
		a_now     = 1'b0;
		b_now     = 1'b0;
		a_chg     = 1'b0;
		b_chg     = 1'b0;
		cfg       = '0;
		cnt       = '0;
		c         = '0;
		e         = 0;
		o         = 0;
		d         = q;
		d.rdata   = '0;
		d.prev    = pin_s;

		// Fractional accumulator makes source ticks from the 200 MHz clock
		acc_sum = {1'b0, q.acc} + {1'b0, rate_khz(q.src)};
		if (acc_sum >= {1'b0, REF_CLK_KHZ}) begin
			d.acc     = ACC_W'(acc_sum - {1'b0, REF_CLK_KHZ});
			base_tick = 1'b1;
		end else begin
			d.acc = acc_sum[ACC_W-1:0];
		end

		// One divider for all channels; a divider of zero divides by 256
		if (q.src >= SRC_1M_DIV) begin
			if (base_tick) begin
				if (q.div_cnt == q.div - ONE_8) begin
					d.div_cnt = '0;
					t_tick    = 1'b1;
				end else begin
					d.div_cnt = q.div_cnt + ONE_8;
				end
			end
		end else begin
			d.div_cnt = '0;
			t_tick    = base_tick;
		end

		if (t_tick) begin
			d.roll  = q.roll + ONE_8;
			roll_ev = (q.roll == ROLL_LAST);
		end

		for (int i = 0; i < NUM_CH; i++) begin
			unique case (q.st[i])
				FO_IDLE: begin
				end
				FO_ARM: begin
					if (roll_ev) begin
						d.st[i]  = FO_RUN;
						d.hc[i]  = '0;
						d.out[i] = 1'b0;
					end
				end
				FO_RUN: begin
					if (t_tick) begin
						// Zero wraps to 255 and so counts 256 ticks
						if (q.hc[i] == q.val[i][7:0] - ONE_8) begin
							d.hc[i]  = '0;
							d.out[i] = ~q.out[i];
						end else begin
							d.hc[i] = q.hc[i] + ONE_8;
						end
					end
				end
				FO_HALT: begin
				end
			endcase
		end

		for (int p = 0; p < NUM_PAIR; p++) begin
			e = 2 * p;
			o = 2 * p + 1;

			// Stop input on the odd channel
			if (q.mode[o] == MODE_STOP) begin
				if (pin_s[o] && !q.prev[o] &&
				    q.edges[p] != q.val[o]) begin
					d.edges[p] = q.edges[p] + ONE_16;
				end
				if (q.edges[p] == q.val[o] &&
				    (q.st[e] == FO_ARM || q.st[e] == FO_RUN)) begin
					d.st[e] = FO_HALT;
				end
			end

			// Quadrature decoding of the pair
			if (q.mode[e] == MODE_QUAD) begin
				a_now   = pin_s[e];
				b_now   = pin_s[o];
				a_chg   = a_now ^ q.prev[e];
				b_chg   = b_now ^ q.prev[o];
				cfg     = q.val[e];
				zero_wr = reg_wr_i && bank_hit(reg_addr_i, ADDR_VALUE_BASE) &&
				          (int'(bank_ch(reg_addr_i)) >> 1 == p) &&
				          (reg_wdata_i[VAL_W-1:0] == '0);
				cnt     = zero_wr ? '0 : q.qcnt[p];
				// Edge after a clear in the same cycle still counts
				if (a_chg ^ b_chg) begin
					if (cfg[IDX_EN_BIT] &&
					    dio_s[cfg[IDX_SEL_LSB +: IDX_SEL_W]]) begin
						cnt = '0;
					end else if (a_now ^ q.prev[o]) begin
						cnt = cnt + ONE_32;
					end else begin
						cnt = cnt - ONE_32;
					end
				end
				d.qcnt[p] = cnt;
			end
		end

		if (reg_wr_i) begin
			c = bank_ch(reg_addr_i);
			if (reg_addr_i == ADDR_CLK_SRC) begin
				d.src = reg_wdata_i[2:0];
			end else if (reg_addr_i == ADDR_DIVIDER) begin
				d.div = reg_wdata_i[7:0];
			end else if (bank_hit(reg_addr_i, ADDR_MODE_BASE)) begin
				d.mode[c] = to_mode(reg_wdata_i[3:0]);
				d.st[c]   = (to_mode(reg_wdata_i[3:0]) == MODE_FREQ) ?
				            FO_ARM : FO_IDLE;
				d.out[c]  = 1'b0;
				d.hc[c]   = '0;
				if (c[0]) begin
					d.edges[c >> 1] = '0;
				end
				if (to_mode(reg_wdata_i[3:0]) == MODE_QUAD) begin
					d.qcnt[c >> 1] = '0;
				end
			end else if (bank_hit(reg_addr_i, ADDR_VALUE_BASE)) begin
				// In quadrature mode a zero clears the count, not the setting
				if (!(q.mode[c] == MODE_QUAD &&
				      reg_wdata_i[VAL_W-1:0] == '0)) begin
					d.val[c] = reg_wdata_i[VAL_W-1:0];
				end
			end
		end

		// Read data reflect state before any write, for one cycle only
		if (reg_rd_i) begin
			c = bank_ch(reg_addr_i);
			if (reg_addr_i == ADDR_CLK_SRC) begin
				d.rdata = {29'h0000_0000, q.src};
			end else if (reg_addr_i == ADDR_DIVIDER) begin
				d.rdata = {24'h00_0000, q.div};
			end else if (bank_hit(reg_addr_i, ADDR_MODE_BASE)) begin
				d.rdata = {28'h000_0000, q.mode[c]};
			end else if (bank_hit(reg_addr_i, ADDR_VALUE_BASE)) begin
				unique case (q.mode[c])
					MODE_QUAD: d.rdata = q.qcnt[c >> 1];
					MODE_STOP: d.rdata = {q.edges[c >> 1],
					                      q.val[c] - q.edges[c >> 1]};
					MODE_FREQ: d.rdata = {16'h0000, q.val[c]};
					MODE_OFF:  d.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q      <= '0;
			q.src  <= SRC_RST;
			q.div  <= DIV_RST;
		end else begin
			q <= d;
		end
	end

	// Halted output keeps its mode but lets the pull-up hold the pin
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			pin_oe_o[i] = (q.st[i] == FO_ARM) || (q.st[i] == FO_RUN);
		end
	end

	assign pin_o       = q.out;
	assign reg_rdata_o = q.rdata;

endmodule : timer_modes

// >>> hdl/timer_pkg.sv
package timer_pkg;

	// Reference clock and timer clock source rates, in kHz
	localparam int           ACC_W        = 18;
	localparam logic [17:0]  REF_CLK_KHZ  = 18'h3_0d40;
	localparam logic [17:0]  RATE_1_KHZ   = 18'h0_03e8;
	localparam logic [17:0]  RATE_4_KHZ   = 18'h0_0fa0;
	localparam logic [17:0]  RATE_12_KHZ  = 18'h0_2ee0;
	localparam logic [17:0]  RATE_48_KHZ  = 18'h0_bb80;

	// Clock source select codes
	localparam logic [2:0]   SRC_4M       = 3'h0;
	localparam logic [2:0]   SRC_12M      = 3'h1;
	localparam logic [2:0]   SRC_48M      = 3'h2;
	localparam logic [2:0]   SRC_1M_DIV   = 3'h3;
	localparam logic [2:0]   SRC_4M_DIV   = 3'h4;
	localparam logic [2:0]   SRC_12M_DIV  = 3'h5;
	localparam logic [2:0]   SRC_48M_DIV  = 3'h6;
	localparam logic [2:0]   SRC_RST      = SRC_48M;
	localparam logic [7:0]   DIV_RST      = 8'h01;
	localparam logic [7:0]   ONE_8        = 8'h01;
	localparam logic [7:0]   ROLL_LAST    = 8'hff;

	// Register byte addresses
	localparam logic [7:0]   ADDR_CLK_SRC    = 8'h00;
	localparam logic [7:0]   ADDR_DIVIDER    = 8'h04;
	localparam logic [7:0]   ADDR_MODE_BASE  = 8'h10;
	localparam logic [7:0]   ADDR_VALUE_BASE = 8'h20;

	// Index configuration fields
	localparam int           IDX_EN_BIT   = 15;
	localparam int           IDX_SEL_LSB  = 0;
	localparam int           IDX_SEL_W    = 5;
	localparam int           DIO_W        = 32;

	localparam int           VAL_W        = 16;
	localparam int           QCNT_W       = 32;
	localparam logic [15:0]  ONE_16       = 16'h0001;
	localparam logic [31:0]  ONE_32       = 32'h0000_0001;

	typedef enum logic [3:0] {
		MODE_OFF  = 4'h0,
		MODE_FREQ = 4'h7,
		MODE_QUAD = 4'h8,
		MODE_STOP = 4'h9
	} mode_t;

	typedef enum logic [1:0] {
		FO_IDLE = 2'b00,
		FO_ARM  = 2'b01,
		FO_RUN  = 2'b11,
		FO_HALT = 2'b10
	} fo_state_t;

	function automatic logic [17:0] rate_khz(input logic [2:0] src);
		unique case (src)
			SRC_4M, SRC_4M_DIV:   rate_khz = RATE_4_KHZ;
			SRC_12M, SRC_12M_DIV: rate_khz = RATE_12_KHZ;
			SRC_1M_DIV:           rate_khz = RATE_1_KHZ;
			default:              rate_khz = RATE_48_KHZ;
		endcase
	endfunction : rate_khz

	function automatic mode_t to_mode(input logic [3:0] code);
		unique case (code)
			MODE_FREQ: to_mode = MODE_FREQ;
			MODE_QUAD: to_mode = MODE_QUAD;
			MODE_STOP: to_mode = MODE_STOP;
			default:   to_mode = MODE_OFF;
		endcase
	endfunction : to_mode

endpackage : timer_pkg

// >>> hdl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	// First stage feeds only the second stage
	always_comb begin
		d    = q;
		d.s1 = async_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_o = q.s2;

endmodule : pin_sync

// >>> verif/timer_modes_props.sv
`timescale 1ns/10ps
module timer_modes_props
	import timer_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [31:0]       reg_rdata_o,
	input  wire logic [NUM_CH-1:0] pin_o,
	input  wire logic [NUM_CH-1:0] pin_oe_o
);
	logic        stop_md_q;
	logic [15:0] stop_cnt_q;
	logic        wr_m0;
	assign wr_m0 = reg_wr_i && reg_addr_i == ADDR_MODE_BASE;
	// Shadow of channel one's mode and stop count
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stop_md_q  <= 1'b0;
			stop_cnt_q <= '0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_MODE_BASE + 8'h04)
				stop_md_q <= reg_wdata_i[3:0] == MODE_STOP;
			if (reg_addr_i == ADDR_VALUE_BASE + 8'h04)
				stop_cnt_q <= reg_wdata_i[15:0];
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == '0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");
	property p_src_w;
		reg_rd_i && reg_addr_i == ADDR_CLK_SRC |=> reg_rdata_o[31:3] == '0;
	endproperty
	a_src_w: assert property (p_src_w)
		else $error("source select too wide");
	property p_div_w;
		reg_rd_i && reg_addr_i == ADDR_DIVIDER |=> reg_rdata_o[31:8] == '0;
	endproperty
	a_div_w: assert property (p_div_w)
		else $error("divider too wide");
	property p_stop_sum;
		reg_rd_i && reg_addr_i == ADDR_VALUE_BASE + 8'h04 && stop_md_q
		|=> reg_rdata_o[31:16] + reg_rdata_o[15:0] == stop_cnt_q;
	endproperty
	a_stop_sum: assert property (p_stop_sum)
		else $error("stop read halves do not add up");
	property p_halt_cause; $fell(pin_oe_o[0]) |-> $past(wr_m0) || stop_md_q;
	endproperty
	a_halt_cause: assert property (p_halt_cause)
		else $error("even output released without cause");
	property p_rearm; $rose(pin_oe_o[0]) |-> $past(wr_m0); endproperty
	a_rearm: assert property (p_rearm)
		else $error("even output restarted without mode write");
	property p_arm_low; $rose(pin_oe_o[0]) |-> !pin_o[0]; endproperty
	a_arm_low: assert property (p_arm_low)
		else $error("armed output not low");
	property p_odd_in; stop_md_q |-> !pin_oe_o[1]; endproperty
	a_odd_in: assert property (p_odd_in)
		else $error("stop channel drives its pin");
endmodule : timer_modes_props

// >>> verif/enc_model.sv
`timescale 1ns/10ps
module enc_model (
	input  wire logic       ref_clk_i,
	input  wire logic       step_i,
	input  wire logic       dir_i,
	input  wire logic [3:0] drv_i,
	input  wire logic [3:0] oe_i,
	output logic      [3:0] pins_o
);
	logic [1:0] ph_q = 2'h0;
	always_ff @(posedge ref_clk_i) begin
		if (step_i) begin
			ph_q <= dir_i ? ph_q + 2'h1 : ph_q - 2'h1;
		end
	end
	// Released pin floats up; stop input jumpered to even output
	assign pins_o[0] = oe_i[0] ? drv_i[0] : 1'b1;
	assign pins_o[1] = pins_o[0];
	assign pins_o[2] = ph_q[1] ^ ph_q[0];
	assign pins_o[3] = ph_q[1];
endmodule : enc_model

// >>> verif/timer_modes_tb.sv
`timescale 1ns/10ps
module timer_modes_tb;
	import timer_pkg::*;
	logic        ref_clk_i   = 1'b0;
	logic        rst_b_i     = 1'b0;
	logic [7:0]  reg_addr_i  = '0;
	logic [31:0] reg_wdata_i = '0;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [3:0]  pin_i;
	logic [3:0]  pin_o;
	logic [3:0]  pin_oe_o;
	logic [31:0] dio_i       = '0;
	logic        step        = 1'b0;
	logic        dir         = 1'b0;
	logic [31:0] rv;
	int          failures    = 0;
	int          n_checks    = 0;
	int          cyc         = 0;
	int          n;
	always #2.5 ref_clk_i = ~ref_clk_i;
	timer_modes dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .dio_i(dio_i));
	enc_model u_enc (.ref_clk_i(ref_clk_i), .step_i(step), .dir_i(dir),
		.drv_i(pin_o), .oe_i(pin_oe_o), .pins_o(pin_i));
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			failures++;
			print_verdict();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i    <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i   <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	task stp(input logic d);
		@(posedge ref_clk_i);
		step <= 1'b1;
		dir  <= d;
		@(posedge ref_clk_i);
		step <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
	endtask : stp
	task freq(input logic [2:0] s, input logic [7:0] dv, input logic [7:0] v,
		input int base);
		int de, num, k, m, d;
		logic p;
		de  = (s >= SRC_1M_DIV) ? int'(dv) : 1;
		num = 4 * (v == 8'h00 ? 256 : int'(v)) * de * int'(REF_CLK_KHZ);
		wr(ADDR_CLK_SRC, {29'h0, s});
		wr(ADDR_DIVIDER, {24'h0, dv});
		wr(ADDR_VALUE_BASE, {24'h0, v});
		wr(ADDR_MODE_BASE, {28'h0, MODE_FREQ});
		rd(ADDR_VALUE_BASE, rv);
		chk("freq_val", {24'h0, v}, rv);
		@(negedge ref_clk_i);
		k = 0;
		while (pin_o[0] !== 1'b1 && k < 30000) begin
			@(negedge ref_clk_i);
			k++;
		end
		// First rising edge comes one half period after the roll
		d = (256 + (v == 8'h00 ? 256 : int'(v))) * de * int'(REF_CLK_KHZ);
		d = d + 10 * base;
		chk("start", 32'h1, (k * base <= d) ? 32'h1 : 32'h0);
		m = 0;
		repeat (4) begin
			p = pin_o[0];
			do begin
				@(negedge ref_clk_i);
				m++;
			end while (pin_o[0] === p && m < 9000);
		end
		d = m * base - num;
		chk("period", 32'h1, (d > -base && d < base) ? 32'h1 : 32'h0);
	endtask : freq
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(ADDR_CLK_SRC, rv);
		chk("clk_src", {29'h0, SRC_RST}, rv);
		rd(ADDR_DIVIDER, rv);
		chk("divider", {24'h0, DIV_RST}, rv);
		rd(8'h08, rv);
		chk("unmapped", 32'h0, rv);
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_CLK_SRC, 32'(i));
			rd(ADDR_CLK_SRC, rv);
			chk("src_code", 32'(i), rv);
		end
		freq(SRC_48M, 8'h01, 8'h02, int'(RATE_48_KHZ));
		freq(SRC_48M, 8'h01, 8'h00, int'(RATE_48_KHZ));
		freq(SRC_4M, 8'h03, 8'h05, int'(RATE_4_KHZ));
		freq(SRC_48M_DIV, 8'h03, 8'h03, int'(RATE_48_KHZ));
		freq(SRC_4M_DIV, 8'h02, 8'h01, int'(RATE_4_KHZ));
		wr(ADDR_MODE_BASE, 32'h0);
		wr(ADDR_CLK_SRC, {29'h0, SRC_48M});
		wr(ADDR_VALUE_BASE + 8'h04, 32'h0000_0003);
		wr(ADDR_MODE_BASE + 8'h04, {28'h0, MODE_STOP});
		rd(ADDR_VALUE_BASE + 8'h04, rv);
		chk("stop_idle", 32'h0000_0003, rv);
		wr(ADDR_MODE_BASE, {28'h0, MODE_FREQ});
		@(negedge ref_clk_i);
		n = 0;
		while (pin_oe_o[0] === 1'b1 && n < 5000) begin
			@(negedge ref_clk_i);
			n++;
		end
		repeat (50) @(negedge ref_clk_i);
		chk("halt_oe", 32'h0, {31'h0, pin_oe_o[0]});
		rd(ADDR_VALUE_BASE + 8'h04, rv);
		chk("stop_read", 32'h0003_0000, rv);
		wr(ADDR_MODE_BASE, {28'h0, MODE_FREQ});
		repeat (50) @(negedge ref_clk_i);
		chk("rehalt", 32'h0, {31'h0, pin_oe_o[0]});
		wr(ADDR_MODE_BASE + 8'h04, {28'h0, MODE_STOP});
		wr(ADDR_MODE_BASE, {28'h0, MODE_FREQ});
		@(negedge ref_clk_i);
		chk("restart", 32'h1, {31'h0, pin_oe_o[0]});
		wr(ADDR_MODE_BASE + 8'h08, {28'h0, MODE_QUAD});
		wr(ADDR_MODE_BASE + 8'h0c, {28'h0, MODE_QUAD});
		rd(ADDR_MODE_BASE + 8'h08, rv);
		chk("quad_mode", {28'h0, MODE_QUAD}, rv);
		repeat (5) stp(1'b1);
		rd(ADDR_VALUE_BASE + 8'h08, rv);
		chk("quad_even", 32'h0000_0005, rv);
		rd(ADDR_VALUE_BASE + 8'h0c, rv);
		chk("quad_odd", 32'h0000_0005, rv);
		repeat (7) stp(1'b0);
		rd(ADDR_VALUE_BASE + 8'h0c, rv);
		wr(ADDR_VALUE_BASE + 8'h08, 32'h0);
		chk("quad_neg", 32'hffff_fffe, rv);
		rd(ADDR_VALUE_BASE + 8'h0c, rv);
		chk("quad_clr", 32'h0, rv);
		wr(ADDR_VALUE_BASE + 8'h08, 32'h0000_8005);
		wr(ADDR_VALUE_BASE + 8'h0c, 32'h0000_8005);
		stp(1'b1);
		dio_i <= 32'h0000_0020;
		repeat (4) @(posedge ref_clk_i);
		rd(ADDR_VALUE_BASE + 8'h08, rv);
		chk("idx_idle", 32'h0000_0001, rv);
		stp(1'b1);
		rd(ADDR_VALUE_BASE + 8'h08, rv);
		chk("idx_zero", 32'h0, rv);
		dio_i <= 32'h0;
		stp(1'b0);
		stp(1'b0);
		rd(ADDR_VALUE_BASE + 8'h08, rv);
		chk("wrap_neg", 32'hffff_fffe, rv);
		print_verdict();
	end
endmodule : timer_modes_tb
bind timer_modes timer_modes_props #(.NUM_CH(NUM_CH)) u_props (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
